// ==== core/spi_controller.sv ====
// Byte serial controller, master or slave, with its software registers.
//
// Summary of operation
// - Selected slave drives data out if enabled
// - Deselected slave: pins input, ignores clock
// - Deselect resets slave bit counter at once
// - Master select output is plain output
// - Master select input must stay high externally
// - Low select in master demotes, sets done
// - Software alone restores master role afterwards
// - Interrupt when enabled, done, global enable
// - Enable bit gates all serial activity
// - Order bit: one LSB first, zero MSB
// - Master bit chooses master or slave role
// - Polarity bit sets idle clock level
// - Phase bit picks sample and setup edges
// - Rate bits divide by 4,16,64,128
// - Double bit halves divider, minimum two clocks
// - External clock at most quarter system clock
// - Done flag on byte end or demotion
// - Done clears by vector or status-data sequence
// - Collision flag on data write mid transfer
// - Status-data sequence clears both; bits read zero
// - Master data write starts shift; read gives buffer
// - Modes 0-3 are polarity, phase; opposite edges
// - Master clocks eight bits then stops
// - Single transmit, double receive buffer; overrun lost
`timescale 1ns/1ps
module spi_controller
  import spi_ctl_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Software register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic [7:0]             rdata,
  // Processor interrupt handshake
  input  wire logic              globalIe,
  input  wire logic              irqAck,
  output logic                   irq,
  // Serial link
  spi_link_if.dev                link
);

  typedef struct packed {
    logic [7:0]   ctrl;
    logic         dbl;
    logic         tcf;
    logic         write_collision_flag;
    logic         armed;
    logic [7:0]   rxBuf;
    logic [7:0]   shift;
    logic [3:0]   bitCnt;
    shift_state_t st;
    logic         sckPrev;
    logic [4:0]   pins;
    logic [7:0]   rdata;
    logic         irq;
    logic         sckOut;
    logic         sckOeN;
    logic         mosiOut;
    logic         mosiOeN;
    logic         misoOut;
    logic         misoOeN;
    logic         ssOut;
    logic         ssOeN;
  } ctl_state_t;

  ctl_state_t s_q, s_d;
  logic       tick;
  logic       en, mst, clock_polarity_bit, clock_phase_bit, lsb, busy, inBit;
  logic       leadEv, trailEv, smpEv, setEv, done, demote, dataAcc;

  // Picks the bit that leaves next for the chosen order.
  function automatic logic outBit(input logic [7:0] v, input logic lsbF);
    return lsbF ? v[0] : v[7];
  endfunction

  // ----------------------------------------------------------------
  // Master clock rate
  // ----------------------------------------------------------------
  spi_rate_tick u_rate (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .run   (s_q.st == ST_SHIFT),
    .rate  (s_q.ctrl[CTL_RATE_HI:CTL_RATE_LO]),
    .dbl   (s_q.dbl),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Flag sets are applied after clears, so an event in the cycle of
  // its clear is never lost.
  always_comb begin
    s_d     = s_q;
    en      = s_q.ctrl[CTL_ENABLE];
    mst     = s_q.ctrl[CTL_MASTER];
    clock_polarity_bit    = s_q.ctrl[CTL_POLARITY];
    clock_phase_bit    = s_q.ctrl[CTL_PHASE];
    lsb     = s_q.ctrl[CTL_ORDER];
    busy    = (s_q.st != ST_IDLE) || (s_q.bitCnt != 4'h0);
    inBit   = mst ? link.miso : link.mosi;
    leadEv  = 1'b0;
    trailEv = 1'b0;
    dataAcc = (rdStb || wrStb) && (addr == OFS_DATA);

    // Edge sources: own divider as master, sampled pin as slave.
    // A late tick from the divider after the byte end must not count.
    if (en && mst) begin
      leadEv  = tick && (s_q.st == ST_SHIFT)
                && (s_q.sckOut == clock_polarity_bit);
      trailEv = tick && (s_q.st == ST_SHIFT) && (s_q.sckOut != clock_polarity_bit);
    end else if (en && !link.ssN) begin
      leadEv  = (link.sck != s_q.sckPrev) && (link.sck != clock_polarity_bit);
      trailEv = (link.sck != s_q.sckPrev) && (link.sck == clock_polarity_bit);
    end
    smpEv = clock_phase_bit ? trailEv : leadEv;
    setEv = clock_phase_bit ? leadEv : trailEv;
    s_d.sckPrev = link.sck;

    // Shifting: sample edges move the register, setup edges launch.
    if (tick && s_q.st == ST_SHIFT) begin
      s_d.sckOut = ~s_q.sckOut;
    end
    if (smpEv) begin
      s_d.shift  = lsb ? {inBit, s_q.shift[7:1]}
                       : {s_q.shift[6:0], inBit};
      s_d.bitCnt = s_q.bitCnt + 4'h1;
    end
    if (setEv && mst) begin
      s_d.mosiOut = outBit(s_d.shift, lsb);
    end
    if (setEv && !mst) begin
      s_d.misoOut = outBit(s_d.shift, lsb);
    end
    // A waiting slave presents its first bit before any clock edge.
    if (!mst && s_q.bitCnt == 4'h0 && !link.ssN) begin
      s_d.misoOut = outBit(s_d.shift, lsb);
    end

    // Byte end: master after its last trailing edge, slave at once.
    done = mst ? (trailEv && s_d.bitCnt == BITS_PER_BYTE)
               : (smpEv && s_d.bitCnt == BITS_PER_BYTE);
    if (done) begin
      s_d.rxBuf  = s_d.shift;
      s_d.bitCnt = 4'h0;
      s_d.st     = ST_IDLE;
    end
    if (s_d.st == ST_IDLE) begin
      s_d.sckOut = clock_polarity_bit;
    end

    // Deselect throws away a partial byte.
    if (!mst && link.ssN) begin
      s_d.bitCnt = 4'h0;
    end
    if (!en) begin
      s_d.bitCnt = 4'h0;
      s_d.st     = ST_IDLE;
    end

    // Clearing sequence: status read arms, data access clears.
    if (rdStb && addr == OFS_STAT && (s_q.tcf || s_q.write_collision_flag)) begin
      s_d.armed = 1'b1;
    end
    if (dataAcc && s_q.armed) begin
      s_d.tcf   = 1'b0;
      s_d.write_collision_flag  = 1'b0;
      s_d.armed = 1'b0;
    end
    if (irqAck) begin
      s_d.tcf = 1'b0;
    end

    // Register writes.
    if (wrStb) begin
      case (addr)
        OFS_CTRL: s_d.ctrl = wdata;
        OFS_STAT: s_d.dbl  = wdata[STA_DOUBLE];
        OFS_PINS: s_d.pins = wdata[4:0];
        OFS_DATA: begin
          if (busy) begin
            s_d.write_collision_flag = 1'b1;
          end else begin
            s_d.shift = wdata;
            if (en && mst) begin
              s_d.st      = ST_SHIFT;
              s_d.bitCnt  = 4'h0;
              s_d.mosiOut = outBit(wdata, lsb);
            end
          end
        end
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end

    // Another master pulls our select input low: step down.
    demote = en && mst && !s_q.pins[PIN_DIR_SS] && !link.ssN;
    if (demote) begin
      s_d.ctrl[CTL_MASTER] = 1'b0;
      s_d.st     = ST_IDLE;
      s_d.bitCnt = 4'h0;
    end
    if (done || demote) begin
      s_d.tcf = 1'b1;
    end

    // Pin directions follow the next role; enables are active low.
    s_d.sckOeN  = !(s_d.ctrl[CTL_ENABLE] && s_d.ctrl[CTL_MASTER]
                    && s_d.pins[PIN_DIR_SCK]);
    s_d.mosiOeN = !(s_d.ctrl[CTL_ENABLE] && s_d.ctrl[CTL_MASTER]
                    && s_d.pins[PIN_DIR_MOSI]);
    s_d.misoOeN = !(s_d.ctrl[CTL_ENABLE] && !s_d.ctrl[CTL_MASTER]
                    && s_d.pins[PIN_DIR_MISO] && !link.ssN);
    s_d.ssOeN   = !(s_d.pins[PIN_DIR_SS]
                    && !(s_d.ctrl[CTL_ENABLE] && !s_d.ctrl[CTL_MASTER]));
    s_d.ssOut   = s_d.pins[PIN_SS_LEVEL];

    // Interrupt request, registered so the pin never glitches.
    s_d.irq = s_d.ctrl[CTL_IRQ_EN] && s_d.tcf && globalIe;

    // Read data stand in the cycle after the strobe only.
    s_d.rdata = 8'h00;
    if (rdStb) begin
      case (addr)
        OFS_CTRL: s_d.rdata = s_q.ctrl;
        OFS_STAT: s_d.rdata = {s_q.tcf, s_q.write_collision_flag, 5'h00, s_q.dbl};
        OFS_DATA: s_d.rdata = s_q.rxBuf;
        OFS_PINS: s_d.rdata = {3'h0, s_q.pins};
        default:  s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.ctrl    <= CTRL_RESET;
      s_q.pins    <= PINS_RESET;
      s_q.sckPrev <= 1'b0;
      s_q.sckOeN  <= 1'b1;
      s_q.mosiOeN <= 1'b1;
      s_q.misoOeN <= 1'b1;
      s_q.ssOeN   <= 1'b1;
      s_q.ssOut   <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign rdata           = s_q.rdata;
  assign irq             = s_q.irq;
  assign link.devSckOut  = s_q.sckOut;
  assign link.devSckOeN  = s_q.sckOeN;
  assign link.devMosiOut = s_q.mosiOut;
  assign link.devMosiOeN = s_q.mosiOeN;
  assign link.devMisoOut = s_q.misoOut;
  assign link.devMisoOeN = s_q.misoOeN;
  assign link.devSsOut   = s_q.ssOut;
  assign link.devSsOeN   = s_q.ssOeN;

endmodule

// ==== core/spi_ctl_pkg.sv ====
// Shared constants and types for the serial controller and its far end.
package spi_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map of the software port
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 2;
  localparam logic [1:0]  OFS_CTRL  = 2'h0;
  localparam logic [1:0]  OFS_STAT  = 2'h1;
  localparam logic [1:0]  OFS_DATA  = 2'h2;
  localparam logic [1:0]  OFS_PINS  = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_IRQ_EN   = 7;
  localparam int CTL_ENABLE   = 6;
  localparam int CTL_ORDER    = 5;
  localparam int CTL_MASTER   = 4;
  localparam int CTL_POLARITY = 3;
  localparam int CTL_PHASE    = 2;
  localparam int CTL_RATE_HI  = 1;
  localparam int CTL_RATE_LO  = 0;
  localparam int STA_DONE     = 7;
  localparam int STA_COLL     = 6;
  localparam int STA_DOUBLE   = 0;
  localparam int PIN_DIR_MOSI = 0;
  localparam int PIN_DIR_MISO = 1;
  localparam int PIN_DIR_SCK  = 2;
  localparam int PIN_DIR_SS   = 3;
  localparam int PIN_SS_LEVEL = 4;

  // ----------------------------------------------------------------
  // Values after reset and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] PINS_RESET = 5'h10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         CLK_PERIOD_NS = 5;

  // Half serial-clock periods in system clocks, index {double, rate}.
  localparam logic [6:0] HALF_PERIOD [8] = '{
    7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20};

  // Far end runs its clock at a quarter of the system clock.
  localparam logic [1:0] FAR_HALF = 2'h2;

  // ----------------------------------------------------------------
  // Shifter states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_END   = 2'b11
  } shift_state_t;

endpackage

// ==== core/spi_link_if.sv ====
// Serial link between the controller and its far end, with pin resolution.
`timescale 1ns/1ps
interface spi_link_if;
  // Resolved pin levels.
  logic sck, mosi, miso, ssN;
  // Controller drive, enables active low.
  logic devSckOut, devSckOeN, devMosiOut, devMosiOeN;
  logic devMisoOut, devMisoOeN, devSsOut, devSsOeN;
  // Far end drive, enables active low.
  logic farSckOut, farSckOeN, farMosiOut, farMosiOeN;
  logic farSsOut, farSsOeN;

  // Undriven clock and data lines fall low; select is pulled high.
  assign sck  = !devSckOeN ? devSckOut : (!farSckOeN ? farSckOut : 1'b0);
  assign mosi = !devMosiOeN ? devMosiOut
              : (!farMosiOeN ? farMosiOut : 1'b0);
  assign miso = !devMisoOeN ? devMisoOut : 1'b0;
  assign ssN  = !devSsOeN ? devSsOut : (!farSsOeN ? farSsOut : 1'b1);

  modport dev (input sck, mosi, miso, ssN,
               output devSckOut, devSckOeN, devMosiOut, devMosiOeN,
               output devMisoOut, devMisoOeN, devSsOut, devSsOeN);
  modport far (input sck, mosi, miso, ssN,
               output farSckOut, farSckOeN, farMosiOut, farMosiOeN,
               output farSsOut, farSsOeN);
endinterface

// ==== core/spi_rate_tick.sv ====
// Serial clock rate generator: one pulse per half period while running.
`timescale 1ns/1ps
module spi_rate_tick
  import spi_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Control
  input  wire logic       run,
  input  wire logic [1:0] rate,
  input  wire logic       dbl,
  // Half-period pulse
  output logic            tick
);

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } tick_state_t;

  tick_state_t s_q, s_d;
  logic [6:0]  half;

  // Counter restarts whenever the shifter is idle, so every byte sees
  // a full first half period.
  always_comb begin
    s_d      = s_q;
    half     = HALF_PERIOD[{dbl, rate}];
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= half - 7'h01) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// ==== core/spi_far_master.sv ====
// Far end: an external master that selects the controller and swaps bytes.
`timescale 1ns/1ps
module spi_far_master
  import spi_ctl_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // User side
  input  wire logic       active,
  input  wire logic [1:0] mode,
  input  wire logic       lsbFirst,
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  output logic [7:0]      rxByte,
  output logic            done,
  output logic            busy,
  // Serial link
  spi_link_if.far         link
);

  typedef struct packed {
    shift_state_t st;
    logic [1:0]   cnt;
    logic [3:0]   bitCnt;
    logic [7:0]   shift;
    logic [7:0]   rx;
    logic         done;
    logic         sck;
    logic         mosi;
    logic         ssN;
    logic         oeN;
  } far_state_t;

  far_state_t s_q, s_d;
  logic       clock_polarity_bit, clock_phase_bit, tick, lead, trail;

  // Byte transfer at a quarter of the system clock; select is held
  // low from start until one half period after the last edge.
  always_comb begin
    s_d      = s_q;
    clock_polarity_bit     = mode[1];
    clock_phase_bit     = mode[0];
    s_d.done = 1'b0;
    tick     = (s_q.st != ST_IDLE) && (s_q.cnt == FAR_HALF - 2'h1);
    lead     = tick && (s_q.st == ST_SHIFT) && (s_q.sck == clock_polarity_bit);
    trail    = tick && (s_q.st == ST_SHIFT) && (s_q.sck != clock_polarity_bit);
    s_d.cnt  = (s_q.st == ST_IDLE || tick) ? 2'h0 : s_q.cnt + 2'h1;
    case (s_q.st)
      ST_IDLE: begin
        s_d.sck = clock_polarity_bit;
        s_d.ssN = 1'b1;
        if (start && active) begin
          s_d.st     = ST_SHIFT;
          s_d.shift  = txByte;
          s_d.bitCnt = 4'h0;
          s_d.ssN    = 1'b0;
          s_d.mosi   = lsbFirst ? txByte[0] : txByte[7];
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          s_d.sck = ~s_q.sck;
        end
        if (clock_phase_bit ? trail : lead) begin
          s_d.shift  = lsbFirst ? {link.miso, s_q.shift[7:1]}
                               : {s_q.shift[6:0], link.miso};
          s_d.bitCnt = s_q.bitCnt + 4'h1;
        end
        if (clock_phase_bit ? lead : trail) begin
          s_d.mosi = lsbFirst ? s_d.shift[0] : s_d.shift[7];
        end
        if (trail && s_d.bitCnt == BITS_PER_BYTE) begin
          s_d.st = ST_END;
          s_d.rx = s_d.shift;
        end
      end
      ST_END: begin
        if (tick) begin
          s_d.st   = ST_IDLE;
          s_d.ssN  = 1'b1;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    s_d.oeN = !active;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q     <= '0;
      s_q.ssN <= 1'b1;
      s_q.oeN <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs.
  assign rxByte          = s_q.rx;
  assign done            = s_q.done;
  assign busy            = (s_q.st != ST_IDLE);
  assign link.farSckOut  = s_q.sck;
  assign link.farSckOeN  = s_q.oeN;
  assign link.farMosiOut = s_q.mosi;
  assign link.farMosiOeN = s_q.oeN;
  assign link.farSsOut   = s_q.ssN;
  assign link.farSsOeN   = s_q.oeN;

endmodule

// ==== dv/spi_link_asserts.sv ====
// Concurrent checks on the serial link between controller and far master.
`timescale 1ns/1ps
module spi_link_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Resolved select and drive signals
  input wire logic ssN,
  input wire logic devSckOeN,
  input wire logic devMosiOeN,
  input wire logic devMisoOeN,
  input wire logic devSsOeN,
  input wire logic farSckOut,
  input wire logic farSckOeN,
  input wire logic farSsOeN
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  // Select is an input pulled low by someone else while we drive sck.
  sequence ssConflict;
    devSsOeN && !ssN && !devSckOeN;
  endsequence
  sequence pinsReleased;
    devSckOeN && devMosiOeN;
  endsequence
  sequence farToggle;
    !farSckOeN && $changed(farSckOut);
  endsequence

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  // Outputs are registered, so relations on them allow a cycle of lag; demotion release allows up to three.
  demote_release_a: assert property (ssConflict |-> ##[1:3] pinsReleased)
    else $error("demoted master kept driving sck or mosi");
  demote_hold_a: assert property (devSsOeN && !ssN && devSckOeN |=> devSckOeN)
    else $error("released sck driven again while selected");
  ss_output_a: assert property (!devSsOeN && !ssN && !devSckOeN |=> !devSckOeN)
    else $error("select used as output caused demotion");
  miso_idle_a: assert property (ssN[*2] |-> devMisoOeN)
    else $error("miso driven while deselected");
  miso_select_a: assert property (!devMisoOeN |-> !$past(ssN))
    else $error("miso driven without select");
  miso_role_a: assert property (!devMisoOeN |-> devSckOeN && devMosiOeN)
    else $error("slave drives a master pin");
  far_half_a: assert property (farToggle |=> $stable(farSckOut))
    else $error("far clock faster than a quarter");
  far_select_a: assert property (farToggle |-> !ssN)
    else $error("far clock moved while select was high");
endmodule

// ==== dv/tb_spi_controller.sv ====
// Self-checking bench: controller registers and far master user side.
`timescale 1ns/1ps
module tb_spi_controller
  import spi_ctl_pkg::*;
;
  logic              clk, rst_n, ce, wrStb, rdStb, globalIe, irqAck, irq;
  logic              active, lsbFirst, start, done, busy;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata, rdata, txByte, rxByte, b, d;
  logic [1:0]        mode;
  logic              p;
  int                miscompares, compares, n, gap, last;

  spi_link_if link ();

  spi_controller i_spi_controller (.clk(clk), .rst_n(rst_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb),
    .rdata(rdata), .globalIe(globalIe), .irqAck(irqAck), .irq(irq),
    .link(link.dev));
  spi_far_master i_spi_far_master (.clk(clk), .rst_n(rst_n), .ce(ce),
    .active(active), .mode(mode), .lsbFirst(lsbFirst), .start(start),
    .txByte(txByte), .rxByte(rxByte), .done(done), .busy(busy),
    .link(link.far));
  spi_link_asserts i_asserts (.clk(clk), .rst_n(rst_n), .ssN(link.ssN),
    .devSckOeN(link.devSckOeN), .devMosiOeN(link.devMosiOeN),
    .devMisoOeN(link.devMisoOeN), .devSsOeN(link.devSsOeN),
    .farSckOut(link.farSckOut), .farSckOeN(link.farSckOeN),
    .farSsOeN(link.farSsOeN));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Strobes drop one edge after rising, so calls never collide.
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask

  task automatic rdv(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdc(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    rdv(a, v);
    chk(v, e);
  endtask

  // One byte from the far master; a short margin lets slave flags land.
  task automatic far(input logic [1:0] m, input logic l, input logic [7:0] t);
    @(posedge clk);
    mode     <= m;
    lsbFirst <= l;
    txByte   <= t;
    start    <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // A hang in any handshake ends the run as a failure.
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n, wrStb, rdStb, globalIe, irqAck, start, lsbFirst} = '0;
    {addr, wdata, mode, txByte} = '0;
    {ce, active} = 2'b11;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(OFS_CTRL, CTRL_RESET);
    rdc(OFS_PINS, {3'h0, PINS_RESET});
    rdc(OFS_STAT, 8'h00);
    $display("test reset done");
    // Slave swaps a byte in every mode and both bit orders.
    wr(OFS_PINS, 8'h02);
    for (int k = 0; k < 8; k++) begin
      b = 8'h1d + 8'(k * 19);
      wr(OFS_CTRL, {2'b01, k[0], 1'b0, k[2:1], 2'b00});
      wr(OFS_DATA, b);
      far(k[2:1], k[0], ~b);
      chk(rxByte, b);
      chk({7'h0, busy}, 8'h00);
      rdc(OFS_STAT, 8'h80);
      rdc(OFS_DATA, ~b);
      rdc(OFS_STAT, 8'h00);
    end
    $display("test slave modes done");
    wr(OFS_CTRL, 8'h00);
    far(2'h0, 1'b0, 8'h66);
    rdc(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'hc0);
    globalIe <= 1'b1;
    far(2'h0, 1'b0, 8'h81);
    chk({7'h0, irq}, 8'h01);
    globalIe <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    globalIe <= 1'b1;
    irqAck   <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
    rdc(OFS_STAT, 8'h00);
    far(2'h0, 1'b0, 8'h42);
    far(2'h0, 1'b0, 8'h24);
    rdc(OFS_STAT, 8'h80);
    rdc(OFS_DATA, 8'h24);
    $display("test enable irq overrun done");
    // Master at every rate; miso is undriven, so zero comes back.
    wr(OFS_PINS, 8'h1d);
    active <= 1'b0;
    for (int r = 0; r < 8; r++) begin
      wr(OFS_STAT, {7'h0, r[2]});
      wr(OFS_CTRL, {4'h5, r[0], 1'b0, r[1:0]});
      wr(OFS_DATA, 8'h5a);
      n = 0;
      gap = 0;
      last = 0;
      p = link.sck;
      for (int c = 0; c < 1200 && n < 16; c++) begin
        @(posedge clk);
        #1;
        if (link.sck !== p) begin
          n++;
          if (n == 2) gap = c - last;
          last = c;
          p = link.sck;
        end
      end
      chk(8'(gap), {1'b0, HALF_PERIOD[r]});
      chk(8'(n), 8'h10);
      repeat (3) @(posedge clk);
      chk({7'h0, link.sck}, {7'h0, r[0]});
      rdc(OFS_STAT, {1'b1, 6'h0, r[2]});
      rdc(OFS_DATA, 8'h00);
      rdc(OFS_STAT, {7'h0, r[2]});
    end
    $display("test master rates done");
    wr(OFS_STAT, 8'h00);
    wr(OFS_CTRL, 8'h53);
    wr(OFS_PINS, 8'h0d);
    wr(OFS_DATA, 8'h5a);
    wr(OFS_DATA, 8'hff);
    rdc(OFS_STAT, 8'h40);
    chk({7'h0, link.ssN}, 8'h00);
    rdc(OFS_CTRL, 8'h53);
    repeat (1100) @(posedge clk);
    rdc(OFS_STAT, 8'hc0);
    rdc(OFS_DATA, 8'h00);
    rdc(OFS_STAT, 8'h00);
    $display("test collision done");
    // A far master selecting us while we are master forces slave role.
    wr(OFS_PINS, 8'h05);
    wr(OFS_CTRL, 8'h50);
    active <= 1'b1;
    far(2'h0, 1'b0, 8'h99);
    active <= 1'b0;
    rdc(OFS_CTRL, 8'h40);
    rdc(OFS_STAT, 8'h80);
    rdv(OFS_DATA, d);
    wr(OFS_CTRL, 8'h50);
    rdc(OFS_CTRL, 8'h50);
    rdc(OFS_STAT, 8'h00);
    $display("test demotion done");
    report_and_stop();
  end
endmodule
